// [sbph_top.sv]
// setup button position handler: modes, timed positions and actions
`default_nettype none
module sbph_top
	import sbph_pkg::*;
#(
	parameter int DWELL = DWELL_CYCLES,
	parameter int DEBOUNCE = DEBOUNCE_CYCLES
) (
	input wire logic clk_i,
	input wire logic sys_rst_i,
	input wire logic button_pin_i,
	input wire logic [MODE_W-1:0] button_global_config_command_i,
	input wire logic [NUM_POS*ACT_W-1:0] button_position_action_command_i,
	input wire logic power_on_default_en_i,
	input wire logic load_db_en_i,
	input wire logic save_after_cal_en_i,
	input wire logic trig_edge_mode_i,
	input wire logic timeout_end_en_i,
	input wire logic read_timeout_i,
	input wire logic good_read_i,
	input wire logic cal_done_i,
	output logic read_cycle_o,
	output logic trig_start_o,
	output logic param_set_sel_o,
	output logic restore_defaults_o,
	output logic save_power_on_o,
	output logic read_rate_o,
	output logic calibrate_o,
	output logic cal_abort_o,
	output logic db_load_o,
	output logic load_master_o,
	output logic target_on_o,
	output logic symbol_cfg_o,
	output logic [NUM_LED-1:0] status_led_o,
	output logic green_flash_o
);
	logic btn;
	logic settled;
	logic btn_q_ff;
	logic press;
	logic release_ev;
	sbph_state_t state_ff;
	logic [POS_W-1:0] pos_ff;
	logic [CNT_W-1:0] dwell_ff;
	logic [MODE_W-1:0] mode;
	logic [POS_W-1:0] nxt_pos;
	logic dwell_done;
	logic advance;
	logic rel_fire;
	logic quick;
	logic [ACT_W-1:0] rel_code;
	logic [ACT_W-1:0] nxt_code;
	logic level_blk_ff;
	logic cal_end;

	assign mode = button_global_config_command_i;

	sbph_debounce #(.STABLE_CYCLES(DEBOUNCE)) u_debounce (
		.clk_i(clk_i),
		.sys_rst_i(sys_rst_i),
		.pin_i(button_pin_i),
		.level_o(btn),
		.settled_o(settled)
	);

	function automatic logic [ACT_W-1:0] code_at(input logic [POS_W-1:0] p,
		input logic [NUM_POS*ACT_W-1:0] a);
		logic [ACT_W-1:0] c;
		c = ACT_DIS;
		for (int i = 1; i <= NUM_POS; i++) begin
			if (p == POS_W'(i))
				c = a[(i-1)*ACT_W +: ACT_W];
		end
		return c;
	endfunction

	// unused codes behave as disabled
	function automatic logic code_live(input logic [ACT_W-1:0] c);
		return c == ACT_RATE || c == ACT_CAL || c == ACT_SAVE ||
			c == ACT_MASTER || c == ACT_TARGET || c == ACT_SYMCFG;
	endfunction

	always_ff @(posedge clk_i or posedge sys_rst_i) begin
		if (sys_rst_i)
			btn_q_ff <= 1'b0;
		else
			btn_q_ff <= btn;
	end

	assign press = btn & ~btn_q_ff & settled;
	assign release_ev = ~btn & btn_q_ff;

	always_comb begin
		nxt_pos = pos_ff;
		// nearest live position above the current one
		for (int i = NUM_POS; i >= 1; i--) begin
			if (POS_W'(i) > pos_ff &&
				code_live(button_position_action_command_i[(i-1)*ACT_W +: ACT_W]))
				nxt_pos = POS_W'(i);
		end
	end

	assign dwell_done = dwell_ff >= CNT_W'(DWELL - 1);
	assign advance = state_ff == ST_HOLD && btn && dwell_done &&
		nxt_pos != pos_ff;
	assign nxt_code = code_at(nxt_pos, button_position_action_command_i);
	assign rel_fire = state_ff == ST_HOLD && release_ev && mode == MODE_ENA;
	assign rel_code = code_at(pos_ff, button_position_action_command_i);
	assign quick = rel_fire && pos_ff == POS_NONE;
	assign cal_end = calibrate_o && cal_done_i;

	// state: power-up check, idle, holding, wait for release
	always_ff @(posedge clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			state_ff <= ST_PWR;
		end else begin
			case (state_ff)
				ST_PWR: begin
					if (settled)
						state_ff <= btn ? ST_BLOCK : ST_IDLE;
				end
				ST_IDLE: begin
					if (press && mode == MODE_ENA)
						state_ff <= ST_HOLD;
				end
				ST_HOLD: begin
					if (mode != MODE_ENA || release_ev)
						state_ff <= ST_IDLE;
				end
				ST_BLOCK: begin
					if (!btn)
						state_ff <= ST_IDLE;
				end
				default: state_ff <= ST_IDLE;
			endcase
		end
	end

	always_ff @(posedge clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			pos_ff <= POS_NONE;
			dwell_ff <= '0;
		end else if (state_ff != ST_HOLD) begin
			pos_ff <= POS_NONE;
			dwell_ff <= '0;
		end else if (advance) begin
			pos_ff <= nxt_pos;
			dwell_ff <= '0;
		end else if (!dwell_done) begin
			dwell_ff <= dwell_ff + CNT_W'(1);
		end
	end

	// power-up hold restores defaults, then waits for the release
	always_ff @(posedge clk_i or posedge sys_rst_i) begin
		if (sys_rst_i)
			restore_defaults_o <= 1'b0;
		else
			restore_defaults_o <= state_ff == ST_PWR && settled && btn &&
				power_on_default_en_i;
	end

	genvar g;
	generate
		for (g = 0; g < NUM_LED; g++) begin : g_led
			always_ff @(posedge clk_i or posedge sys_rst_i) begin
				if (sys_rst_i)
					status_led_o[g] <= 1'b0;
				else if (state_ff == ST_HOLD && mode == MODE_ENA && btn)
					status_led_o[g] <= POS_W'(g) < pos_ff;
				else
					status_led_o[g] <= 1'b0;
			end
		end
	endgenerate

	always_ff @(posedge clk_i or posedge sys_rst_i) begin
		if (sys_rst_i)
			green_flash_o <= 1'b0;
		else
			green_flash_o <= state_ff == ST_HOLD && mode == MODE_ENA && btn &&
				pos_ff != POS_NONE;
	end

	// trigger setting: read cycle control
	always_ff @(posedge clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			read_cycle_o <= 1'b0;
			trig_start_o <= 1'b0;
			level_blk_ff <= 1'b0;
		end else if (mode != MODE_TRIG) begin
			read_cycle_o <= 1'b0;
			trig_start_o <= 1'b0;
			level_blk_ff <= 1'b0;
		end else if (state_ff != ST_IDLE) begin
			trig_start_o <= 1'b0;
		end else if (trig_edge_mode_i) begin
			level_blk_ff <= 1'b0;
			trig_start_o <= press;
			if (press)
				read_cycle_o <= 1'b1;
			else if (good_read_i || read_timeout_i)
				read_cycle_o <= 1'b0;
		end else begin
			trig_start_o <= press;
			if (!btn) begin
				read_cycle_o <= 1'b0;
				level_blk_ff <= 1'b0;
			end else if (read_cycle_o && read_timeout_i && timeout_end_en_i) begin
				read_cycle_o <= 1'b0;
				level_blk_ff <= 1'b1;
			end else if (!level_blk_ff) begin
				read_cycle_o <= 1'b1;
			end
		end
	end

	always_ff @(posedge clk_i or posedge sys_rst_i) begin
		if (sys_rst_i)
			param_set_sel_o <= 1'b0;
		else if (mode == MODE_PSW && state_ff == ST_IDLE && press)
			param_set_sel_o <= ~param_set_sel_o;
	end

	// actions run on release, except targeting which runs when reached
	always_ff @(posedge clk_i or posedge sys_rst_i) begin
		if (sys_rst_i)
			read_rate_o <= 1'b0;
		else if (rel_fire && rel_code == ACT_RATE)
			read_rate_o <= 1'b1;
		else if (quick)
			read_rate_o <= 1'b0;
	end

	always_ff @(posedge clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			calibrate_o <= 1'b0;
			cal_abort_o <= 1'b0;
		end else begin
			cal_abort_o <= quick && calibrate_o;
			if (rel_fire && rel_code == ACT_CAL)
				calibrate_o <= 1'b1;
			else if (quick || cal_done_i)
				calibrate_o <= 1'b0;
		end
	end

	always_ff @(posedge clk_i or posedge sys_rst_i) begin
		if (sys_rst_i)
			db_load_o <= 1'b0;
		else
			db_load_o <= cal_end && load_db_en_i;
	end

	always_ff @(posedge clk_i or posedge sys_rst_i) begin
		if (sys_rst_i)
			save_power_on_o <= 1'b0;
		else
			save_power_on_o <= (rel_fire && rel_code == ACT_SAVE) ||
				(cal_end && save_after_cal_en_i);
	end

	always_ff @(posedge clk_i or posedge sys_rst_i) begin
		if (sys_rst_i)
			load_master_o <= 1'b0;
		else
			load_master_o <= rel_fire && rel_code == ACT_MASTER;
	end

	always_ff @(posedge clk_i or posedge sys_rst_i) begin
		if (sys_rst_i)
			target_on_o <= 1'b0;
		else if (advance && nxt_code == ACT_TARGET && mode == MODE_ENA)
			target_on_o <= 1'b1;
		else if (quick)
			target_on_o <= 1'b0;
	end

	always_ff @(posedge clk_i or posedge sys_rst_i) begin
		if (sys_rst_i)
			symbol_cfg_o <= 1'b0;
		else if (rel_fire && rel_code == ACT_SYMCFG)
			symbol_cfg_o <= 1'b1;
		else if (quick)
			symbol_cfg_o <= 1'b0;
	end

	property p_disabled_quiet;
		@(posedge clk_i) disable iff (sys_rst_i)
		mode == MODE_DIS |=> !trig_start_o && !load_master_o &&
			!green_flash_o && !read_cycle_o;
	endproperty
	a_disabled_quiet: assert property (p_disabled_quiet)
		else $error("button acted while disabled");

	property p_trig_no_leds;
		@(posedge clk_i) disable iff (sys_rst_i)
		mode == MODE_TRIG |=> status_led_o == '0 && !load_master_o;
	endproperty
	a_trig_no_leds: assert property (p_trig_no_leds)
		else $error("position logic ran in trigger setting");

	property p_level_release;
		@(posedge clk_i) disable iff (sys_rst_i)
		mode == MODE_TRIG && !trig_edge_mode_i && !btn |=> !read_cycle_o;
	endproperty
	a_level_release: assert property (p_level_release)
		else $error("level cycle outlived release");

	property p_edge_goodread;
		@(posedge clk_i) disable iff (sys_rst_i)
		mode == MODE_TRIG && trig_edge_mode_i && state_ff == ST_IDLE &&
			good_read_i && !press |=> !read_cycle_o;
	endproperty
	a_edge_goodread: assert property (p_edge_goodread)
		else $error("edge cycle not ended by good read");

	property p_param_toggle;
		@(posedge clk_i) disable iff (sys_rst_i)
		mode == MODE_PSW && state_ff == ST_IDLE && press |=>
			param_set_sel_o != $past(param_set_sel_o);
	endproperty
	a_param_toggle: assert property (p_param_toggle)
		else $error("parameter set did not swap");

	property p_cal_db;
		@(posedge clk_i) disable iff (sys_rst_i)
		cal_end |=> db_load_o == $past(load_db_en_i) &&
			save_power_on_o == $past(save_after_cal_en_i) && !calibrate_o;
	endproperty
	a_cal_db: assert property (p_cal_db)
		else $error("calibration end effects wrong");

	property p_led_thermo;
		@(posedge clk_i) disable iff (sys_rst_i)
		!status_led_o[NUM_LED-1] &&
			((status_led_o + NUM_LED'(1)) & status_led_o) == '0;
	endproperty
	a_led_thermo: assert property (p_led_thermo)
		else $error("status lamps not cumulative");

	property p_quick_none;
		@(posedge clk_i) disable iff (sys_rst_i)
		quick |=> !load_master_o && !save_power_on_o && !calibrate_o &&
			!read_rate_o && !target_on_o;
	endproperty
	a_quick_none: assert property (p_quick_none)
		else $error("quick press started an action");

	property p_target_early;
		@(posedge clk_i) disable iff (sys_rst_i)
		advance && nxt_code == ACT_TARGET && mode == MODE_ENA |=>
			target_on_o && btn_q_ff;
	endproperty
	a_target_early: assert property (p_target_early)
		else $error("targeting waited for release");

	property p_pos_live;
		@(posedge clk_i) disable iff (sys_rst_i)
		pos_ff != POS_NONE |->
			code_live(code_at(pos_ff, button_position_action_command_i)) ||
			$changed(button_position_action_command_i);
	endproperty
	a_pos_live: assert property (p_pos_live)
		else $error("stepped onto a disabled position");

	c_master: cover property (@(posedge clk_i) disable iff (sys_rst_i)
		load_master_o);
	c_cal_db: cover property (@(posedge clk_i) disable iff (sys_rst_i)
		db_load_o);
	c_pos4: cover property (@(posedge clk_i) disable iff (sys_rst_i)
		status_led_o[NUM_POS-1]);
	c_restore: cover property (@(posedge clk_i) disable iff (sys_rst_i)
		restore_defaults_o);
endmodule
`default_nettype wire

// [sbph_pkg.sv]
// constants and types shared by the setup button position handler
`default_nettype none
package sbph_pkg;
	localparam int CLK_FREQ_HZ = 100_000_000;
	localparam int CLK_PER_MS = CLK_FREQ_HZ / 1000;
	// hold time per position and debounce time, in ms
	localparam int DWELL_TIME_MS = 1000;
	localparam int DEBOUNCE_TIME_MS = 10;
	localparam int DWELL_CYCLES = DWELL_TIME_MS * CLK_PER_MS;
	localparam int DEBOUNCE_CYCLES = DEBOUNCE_TIME_MS * CLK_PER_MS;
	localparam int CNT_W = 32;
	localparam int NUM_POS = 4;
	localparam int NUM_LED = 5;
	localparam int POS_W = 3;
	localparam int ACT_W = 4;
	localparam int MODE_W = 3;
	// global button setting codes
	localparam logic [MODE_W-1:0] MODE_DIS = 3'h0;
	localparam logic [MODE_W-1:0] MODE_ENA = 3'h1;
	localparam logic [MODE_W-1:0] MODE_TRIG = 3'h2;
	localparam logic [MODE_W-1:0] MODE_PSW = 3'h4;
	// per-position action codes; 4, 6 and 8 are unused
	localparam logic [ACT_W-1:0] ACT_DIS = 4'h0;
	localparam logic [ACT_W-1:0] ACT_RATE = 4'h1;
	localparam logic [ACT_W-1:0] ACT_CAL = 4'h2;
	localparam logic [ACT_W-1:0] ACT_SAVE = 4'h3;
	localparam logic [ACT_W-1:0] ACT_MASTER = 4'h5;
	localparam logic [ACT_W-1:0] ACT_TARGET = 4'h7;
	localparam logic [ACT_W-1:0] ACT_SYMCFG = 4'h9;
	localparam logic [POS_W-1:0] POS_NONE = 3'h0;
	typedef enum logic [3:0] {
		ST_PWR = 4'b0001,
		ST_IDLE = 4'b0010,
		ST_HOLD = 4'b0100,
		ST_BLOCK = 4'b1000
	} sbph_state_t;
endpackage
`default_nettype wire

// [sbph_debounce.sv]
// two-stage synchroniser and debouncer for the button pin
`default_nettype none
module sbph_debounce #(
	parameter int STABLE_CYCLES = 16
) (
	input wire logic clk_i,
	input wire logic sys_rst_i,
	input wire logic pin_i,
	output logic level_o,
	output logic settled_o
);
	logic sync1_ff;
	logic sync2_ff;
	logic [31:0] cnt_ff;

	always_ff @(posedge clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			sync1_ff <= 1'b0;
			sync2_ff <= 1'b0;
		end else begin
			sync1_ff <= pin_i;
			sync2_ff <= sync1_ff;
		end
	end

	// after the first settle, level only follows once the pin has been steady for the full window;
	// before the first settle level follows at once and any change restarts the count
	always_ff @(posedge clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			cnt_ff <= 32'h0;
			level_o <= 1'b0;
			settled_o <= 1'b0;
		end else if (sync2_ff == level_o && settled_o) begin
			cnt_ff <= 32'h0;
		end else if (!settled_o && sync2_ff != level_o) begin
			cnt_ff <= 32'h0;
			level_o <= sync2_ff;
		end else if (cnt_ff >= 32'(STABLE_CYCLES - 1)) begin
			cnt_ff <= 32'h0;
			level_o <= sync2_ff;
			settled_o <= 1'b1;
		end else begin
			cnt_ff <= cnt_ff + 32'h1;
		end
	end
endmodule
`default_nettype wire

// [sbph_operator.sv]
// operator model that works the setup push-button
`default_nettype none
module sbph_operator (
	input wire logic clk_i,
	output logic btn_o
);
	timeunit 1ns;
	timeprecision 1ps;
	initial btn_o = 1'b0;
	// contact chatters once before it settles
	task automatic press();
		@(negedge clk_i) btn_o = 1'b1;
		@(negedge clk_i) btn_o = 1'b0;
		@(negedge clk_i) btn_o = 1'b1;
	endtask
	task automatic lift();
		@(negedge clk_i) btn_o = 1'b0;
	endtask
	// quick press, well short of one dwell
	task automatic tap();
		press();
		repeat (10) @(negedge clk_i);
		lift();
		// let the release settle, else the next press merges with this one
		repeat (12) @(negedge clk_i);
	endtask
endmodule
`default_nettype wire

// [sbph_top_tb.sv]
// self-checking bench for the setup button position handler
`default_nettype none
module sbph_top_tb
	import sbph_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	// short dwell keeps the run small; hold limits below derive from it
	localparam int D = 20;
	logic clk_i = 1'b0;
	logic sys_rst_i = 1'b1;
	logic btn;
	logic [MODE_W-1:0] mode = MODE_DIS;
	logic [NUM_POS*ACT_W-1:0] acts = 16'h0000;
	logic pod_en = 1'b1;
	logic db_en = 1'b0;
	logic sac_en = 1'b0;
	logic edge_md = 1'b0;
	logic to_en = 1'b0;
	logic tmo = 1'b0;
	logic good = 1'b0;
	logic cdone = 1'b0;
	logic rc, ts, ps, rd, sp, rr, ca, ab, db, lm, tg, sc, gf;
	logic [NUM_LED-1:0] led;
	logic [5:0] lv;
	int n [6];
	int e [6];
	int miscompares = 0;
	int comparisons = 0;
	assign lv = {sc, tg, ca, rr, ps, rc};
	always #5 clk_i = ~clk_i;
	sbph_operator i_op (.clk_i(clk_i), .btn_o(btn));
	sbph_top #(.DWELL(D), .DEBOUNCE(4)) i_dut (
		.clk_i(clk_i), .sys_rst_i(sys_rst_i), .button_pin_i(btn),
		.button_global_config_command_i(mode),
		.button_position_action_command_i(acts),
		.power_on_default_en_i(pod_en), .load_db_en_i(db_en),
		.save_after_cal_en_i(sac_en), .trig_edge_mode_i(edge_md),
		.timeout_end_en_i(to_en), .read_timeout_i(tmo),
		.good_read_i(good), .cal_done_i(cdone),
		.read_cycle_o(rc), .trig_start_o(ts), .param_set_sel_o(ps),
		.restore_defaults_o(rd), .save_power_on_o(sp),
		.read_rate_o(rr), .calibrate_o(ca), .cal_abort_o(ab),
		.db_load_o(db), .load_master_o(lm), .target_on_o(tg),
		.symbol_cfg_o(sc), .status_led_o(led), .green_flash_o(gf)
	);
	// pulses are counted so stray ones show up too
	always @(posedge clk_i) begin
		n[0] += int'(ts === 1'b1);
		n[1] += int'(rd === 1'b1);
		n[2] += int'(sp === 1'b1);
		n[3] += int'(ab === 1'b1);
		n[4] += int'(db === 1'b1);
		n[5] += int'(lm === 1'b1);
	end
	task automatic close_out();
		if (miscompares == 0 && comparisons > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	task automatic chk(string nm, logic [31:0] x, logic [31:0] g);
		comparisons++;
		if (g !== x) begin
			miscompares++;
			$display("wrong value %s expected %0h seen %0h", nm, x, g);
		end
	endtask
	task automatic cyc(int k);
		repeat (k) @(negedge clk_i);
	endtask
	task automatic chk_cnt();
		for (int i = 0; i < 6; i++)
			chk($sformatf("pulse count %0d", i), e[i], n[i]);
	endtask
	task automatic wait_lv(logic [5:0] x);
		for (int i = 0; i < 200 && lv !== x; i++)
			@(negedge clk_i);
		chk("levels", x, lv);
	endtask
	task automatic hold_to(logic [4:0] x, int lim);
		i_op.press();
		for (int i = 0; i < lim && led !== x; i++)
			@(negedge clk_i);
		chk("status_led", x, led);
		chk("green_flash", 1, gf);
	endtask
	// release well inside the dwell so the next position is never reached
	task automatic let_go();
		cyc(2);
		i_op.lift();
		cyc(15);
		chk("status_led", 0, led);
		chk("green_flash", 0, gf);
	endtask
	task automatic t_power_up();
		for (int i = 0; i < 40 && n[1] == 0; i++)
			@(negedge clk_i);
		e[1] = 1;
		i_op.lift();
		cyc(20);
		chk_cnt();
		chk("levels", 0, lv);
	endtask
	task automatic t_off(logic [MODE_W-1:0] m);
		mode = m;
		acts = {4{ACT_SAVE}};
		i_op.press();
		cyc(3 * D);
		chk("status_led", 0, led);
		i_op.lift();
		cyc(15);
		wait_lv(6'h00);
		chk_cnt();
	endtask
	task automatic t_switch();
		mode = MODE_PSW;
		i_op.tap();
		wait_lv(6'h02);
		i_op.tap();
		wait_lv(6'h00);
	endtask
	task automatic t_level();
		mode = MODE_TRIG;
		i_op.press();
		e[0]++;
		wait_lv(6'h01);
		cyc(3 * D);
		chk("status_led", 0, led);
		i_op.lift();
		cyc(15);
		chk("levels", 0, lv);
		to_en = 1'b1;
		i_op.press();
		e[0]++;
		wait_lv(6'h01);
		tmo = 1'b1;
		cyc(1);
		tmo = 1'b0;
		cyc(3);
		chk("levels", 0, lv);
		i_op.lift();
		cyc(15);
		chk_cnt();
	endtask
	task automatic t_edge();
		edge_md = 1'b1;
		i_op.tap();
		e[0]++;
		cyc(15);
		chk("levels", 6'h01, lv);
		good = 1'b1;
		cyc(1);
		good = 1'b0;
		cyc(3);
		chk("levels", 0, lv);
		i_op.tap();
		cyc(15);
		i_op.tap();
		e[0] += 2;
		cyc(15);
		chk("levels", 6'h01, lv);
		tmo = 1'b1;
		cyc(1);
		tmo = 1'b0;
		cyc(3);
		chk("levels", 0, lv);
		chk_cnt();
		edge_md = 1'b0;
	endtask
	task automatic t_positions();
		mode = MODE_ENA;
		acts = {ACT_MASTER, ACT_SAVE, ACT_CAL, ACT_RATE};
		i_op.tap();
		cyc(15);
		chk("levels", 0, lv);
		chk_cnt();
		hold_to(5'h01, 4 * D);
		let_go();
		chk("levels", 6'h04, lv);
		i_op.tap();
		cyc(15);
		chk("levels", 0, lv);
		hold_to(5'h03, 4 * D);
		let_go();
		chk("levels", 6'h08, lv);
		i_op.tap();
		e[3]++;
		cyc(15);
		chk("levels", 0, lv);
		db_en = 1'b1;
		sac_en = 1'b1;
		hold_to(5'h03, 4 * D);
		let_go();
		cdone = 1'b1;
		cyc(1);
		cdone = 1'b0;
		e[4]++;
		e[2]++;
		cyc(3);
		chk("levels", 0, lv);
		hold_to(5'h07, 4 * D);
		let_go();
		e[2]++;
		hold_to(5'h0f, 5 * D);
		let_go();
		e[5]++;
		chk_cnt();
	endtask
	task automatic t_target();
		acts = {ACT_DIS, ACT_DIS, ACT_SYMCFG, ACT_TARGET};
		hold_to(5'h01, 4 * D);
		cyc(3);
		chk("levels", 6'h10, lv);
		let_go();
		chk("levels", 6'h10, lv);
		i_op.tap();
		cyc(15);
		chk("levels", 0, lv);
		hold_to(5'h03, 4 * D);
		let_go();
		chk("levels", 6'h30, lv);
		i_op.tap();
		cyc(15);
		chk("levels", 0, lv);
	endtask
	// unused codes 6 and 8 must be stepped over at once
	task automatic t_skip();
		acts = {4'h4, ACT_SAVE, 4'h8, 4'h6};
		hold_to(5'h07, D + 15);
		let_go();
		e[2]++;
		chk_cnt();
	endtask
	initial begin
		i_op.press();
		sys_rst_i = 1'b0;
		t_power_up();
		t_off(MODE_DIS);
		t_off(3'h3);
		t_switch();
		t_level();
		t_edge();
		t_positions();
		t_target();
		t_skip();
		close_out();
	end
	// whole sequence needs some 1250 cycles; 30000, some 24 times that, is a hang
	initial begin
		#300000;
		miscompares++;
		close_out();
	end
endmodule
`default_nettype wire
